// file: rtl/lpmc_pkg.sv
/*
  Constants, register map and mode encoding for the low-power mode controller.
  Assumes a single 100 MHz system clock and an AXI4-Lite register port.
*/
`default_nettype none
package lpmc_pkg;
  localparam int AXI_AW = 8;
  localparam int AXI_DW = 32;
  localparam logic [AXI_AW-1:0] CTRL_OFFSET   = 8'h00;
  localparam logic [AXI_AW-1:0] STATUS_OFFSET = 8'h04;
  localparam int CTRL_WSEL_POS = 0;
  localparam int CTRL_LOW_SPEED_ON_FLAG_POS = 1;
  localparam int STATUS_MODE_POS = 0;
  localparam int STATUS_OPT_POS  = 8;
  localparam logic CTRL_WSEL_RST = 1'b0;
  localparam logic CTRL_LOW_SPEED_ON_FLAG_RST = 1'b0;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int NUM_IRQ = 7;
  localparam int IRQ_EXTERNAL_IRQ_ZERO_IDX = 0;
  localparam int IRQ_TIMER_A_IDX = 2;
  localparam int SYNC_STAGES = 2;

  typedef enum logic [4:0] {
    MODE_ACTIVE    = 5'h01,
    MODE_STANDBY   = 5'h02,
    MODE_STOP      = 5'h04,
    MODE_WATCH     = 5'h08,
    MODE_SUBACTIVE = 5'h10
  } lpmc_mode_type;

  localparam int CTL_CPU_CLK   = 0;
  localparam int CTL_PER_CLK   = 1;
  localparam int CTL_CLK_FUNC  = 2;
  localparam int CTL_SYS_OSC   = 3;
  localparam int CTL_SUB_OSC   = 4;
  localparam int CTL_RAM_KEEP  = 5;
  localparam int CTL_REG_KEEP  = 6;
  localparam int CTL_REG_RST   = 7;
  localparam int CTL_PORT_MODE_REG_B_KEEP = 8;
  localparam int CTL_IO_KEEP   = 9;
  localparam int CTL_IO_RST    = 10;
  localparam int CTL_PIN_DRV   = 11;
  localparam int CTL_ADC       = 12;
  localparam int CTL_TIMER_BC  = 13;
  localparam int CTL_TIMER_A   = 14;
  localparam int CTL_SER_IRQ   = 15;
  localparam int CTL_W = 16;
  localparam logic [CTL_W-1:0] CTL_ACTIVE_RST = 16'hF81F;
endpackage : lpmc_pkg
`default_nettype wire

// file: rtl/lpmc_sync.sv
/*
  Two-stage synchroniser for pin inputs, one chain per bit.
  Assumes the inputs are asynchronous to the system clock.
*/
`timescale 1ns/1ps
`default_nettype none
module lpmc_sync
  import lpmc_pkg::*;
#(
  parameter int WIDTH = 1
)
(
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);
  for (genvar i = 0; i < WIDTH; i++)
  begin : g_bit
    logic [SYNC_STAGES-1:0] chain_q;
    always_ff @(posedge clk_in or posedge rst_in)
    begin
      if (rst_in)
        chain_q <= '0;
      else
        chain_q <= {chain_q[SYNC_STAGES-2:0], async_in[i]};
    end
    assign sync_out[i] = chain_q[SYNC_STAGES-1];
  end
endmodule : lpmc_sync
`default_nettype wire

// file: rtl/lpmc_axil_slave.sv
/*
  AXI4-Lite slave front end: accepts address and data in either order,
  issues one write strobe, and answers reads one cycle after acceptance.
  Assumes the parent decodes addresses combinationally.
*/
`timescale 1ns/1ps
`default_nettype none
module lpmc_axil_slave
  import lpmc_pkg::*;
(
  input  wire logic              clk_in,
  input  wire logic              rst_in,
  input  wire logic [AXI_AW-1:0] awaddr_in,
  input  wire logic              awvalid_in,
  output var  logic              awready_out,
  input  wire logic [AXI_DW-1:0] wdata_in,
  input  wire logic [3:0]        wstrb_in,
  input  wire logic              wvalid_in,
  output var  logic              wready_out,
  output var  logic [1:0]        bresp_out,
  output var  logic              bvalid_out,
  input  wire logic              bready_in,
  input  wire logic              arvalid_in,
  output var  logic              arready_out,
  output var  logic [AXI_DW-1:0] rdata_out,
  output var  logic [1:0]        rresp_out,
  output var  logic              rvalid_out,
  input  wire logic              rready_in,
  output var  logic              wr_en_out,
  output var  logic [AXI_AW-1:0] wr_addr_out,
  output var  logic [AXI_DW-1:0] wr_data_out,
  output var  logic [3:0]        wr_strb_out,
  input  wire logic              wr_ok_in,
  input  wire logic [AXI_DW-1:0] rd_data_in,
  input  wire logic              rd_ok_in
);
  logic              aw_full_q, aw_full_d, w_full_q, w_full_d;
  logic [AXI_AW-1:0] addr_q, addr_d;
  logic [AXI_DW-1:0] data_q, data_d, rdata_q, rdata_d;
  logic [3:0]        strb_q, strb_d;
  logic              bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [1:0]        bresp_q, bresp_d, rresp_q, rresp_d;

  assign awready_out = !aw_full_q && !bvalid_q;
  assign wready_out  = !w_full_q && !bvalid_q;
  assign arready_out = !rvalid_q;
  assign wr_en_out   = aw_full_q && w_full_q && !bvalid_q;
  assign wr_addr_out = addr_q;
  assign wr_data_out = data_q;
  assign wr_strb_out = strb_q;
  assign bvalid_out  = bvalid_q;
  assign bresp_out   = bresp_q;
  assign rvalid_out  = rvalid_q;
  assign rresp_out   = rresp_q;
  assign rdata_out   = rdata_q;

  always_comb
  begin
    aw_full_d = aw_full_q;
    w_full_d  = w_full_q;
    addr_d    = addr_q;
    data_d    = data_q;
    strb_d    = strb_q;
    bvalid_d  = bvalid_q && !bready_in;
    bresp_d   = bresp_q;
    rvalid_d  = rvalid_q && !rready_in;
    rresp_d   = rresp_q;
    rdata_d   = rdata_q;
    if (awvalid_in && awready_out)
    begin
      aw_full_d = 1'b1;
      addr_d    = awaddr_in;
    end
    if (wvalid_in && wready_out)
    begin
      w_full_d = 1'b1;
      data_d   = wdata_in;
      strb_d   = wstrb_in;
    end
    if (wr_en_out)
    begin
      aw_full_d = 1'b0;
      w_full_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = wr_ok_in ? RESP_OKAY : RESP_SLVERR;
    end
    if (arvalid_in && arready_out)
    begin
      rvalid_d = 1'b1;
      rdata_d  = rd_ok_in ? rd_data_in : '0;
      rresp_d  = rd_ok_in ? RESP_OKAY : RESP_SLVERR;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      addr_q    <= '0;
      data_q    <= '0;
      strb_q    <= '0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
      rvalid_q  <= 1'b0;
      rresp_q   <= RESP_OKAY;
      rdata_q   <= '0;
    end
    else
    begin
      aw_full_q <= aw_full_d;
      w_full_q  <= w_full_d;
      addr_q    <= addr_d;
      data_q    <= data_d;
      strb_q    <= strb_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      rvalid_q  <= rvalid_d;
      rresp_q   <= rresp_d;
      rdata_q   <= rdata_d;
    end
  end
endmodule : lpmc_axil_slave
`default_nettype wire

// file: rtl/lpmc_mode_ctrl.sv
/*
  Low-power mode controller: sequences active, standby, stop, watch and
  optional subactive modes, and drives clock, retention and pin controls.
  Assumes instruction strobes, interrupt enable and unmasked interrupt
  requests come from the CPU core on the same clock; RST_IN is the device
  reset and is asynchronous.
*/
// Our own choices: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`default_nettype none
module lpmc_mode_ctrl
  import lpmc_pkg::*;
#(
  parameter bit SUBACTIVE_OPTION = 1'b1
)
(
  input  wire logic               SYS_CLK_IN,
  input  wire logic               RST_IN,
  input  wire logic [AXI_AW-1:0]  S_AXI_AWADDR_IN,
  input  wire logic               S_AXI_AWVALID_IN,
  output var  logic               S_AXI_AWREADY_OUT,
  input  wire logic [AXI_DW-1:0]  S_AXI_WDATA_IN,
  input  wire logic [3:0]         S_AXI_WSTRB_IN,
  input  wire logic               S_AXI_WVALID_IN,
  output var  logic               S_AXI_WREADY_OUT,
  output var  logic [1:0]         S_AXI_BRESP_OUT,
  output var  logic               S_AXI_BVALID_OUT,
  input  wire logic               S_AXI_BREADY_IN,
  input  wire logic [AXI_AW-1:0]  S_AXI_ARADDR_IN,
  input  wire logic               S_AXI_ARVALID_IN,
  output var  logic               S_AXI_ARREADY_OUT,
  output var  logic [AXI_DW-1:0]  S_AXI_RDATA_OUT,
  output var  logic [1:0]         S_AXI_RRESP_OUT,
  output var  logic               S_AXI_RVALID_OUT,
  input  wire logic               S_AXI_RREADY_IN,
  input  wire logic               STANDBY_INSTRUCTION_IN,
  input  wire logic               STOP_INSTRUCTION_IN,
  input  wire logic               GLOBAL_IRQ_ENABLE_IN,
  input  wire logic [NUM_IRQ-1:0] IRQ_REQUEST_IN,
  input  wire logic               SERIAL_EXT_CLK_MODE_IN,
  input  wire logic               SERIAL_SCK_PIN_IN,
  output var  logic [4:0]         MODE_OUT,
  output var  logic               CPU_CLK_EN_OUT,
  output var  logic               PERIPHERAL_CLOCK_EN_OUT,
  output var  logic               CLK_FUNC_EN_OUT,
  output var  logic               SYS_OSC_EN_OUT,
  output var  logic               SUB_OSC_EN_OUT,
  output var  logic               RAM_RETAIN_OUT,
  output var  logic               REG_RETAIN_OUT,
  output var  logic               REG_RESET_OUT,
  output var  logic               PORT_MODE_REG_B_KEEP_OUT,
  output var  logic               IO_RETAIN_OUT,
  output var  logic               IO_RESET_OUT,
  output var  logic               PIN_DRIVE_EN_OUT,
  output var  logic               ADC_EN_OUT,
  output var  logic               TIMER_BC_EN_OUT,
  output var  logic               TIMER_A_EN_OUT,
  output var  logic               SERIAL_IRQ_EN_OUT,
  output var  logic               SERIAL_SHIFT_OUT,
  output var  logic               IRQ_SERVICE_EN_OUT,
  output var  logic               INSN_AS_NOP_OUT,
  output var  logic               RESUME_NEXT_OUT
);
  lpmc_mode_type     mode_q, mode_d;
  logic [CTL_W-1:0]  ctl_q, ctl_d;
  logic              wsel_q, wsel_d, low_speed_on_flag_q, low_speed_on_flag_d;
  logic              nop_q, nop_d, resume_q, resume_d;
  logic              svc_q, svc_d, shift_q, shift_d;
  logic              sck_prev_q, sck_sync;
  logic              wr_en, wr_ok, rd_ok;
  logic [AXI_AW-1:0] wr_addr;
  logic [AXI_DW-1:0] wr_data, rd_data;
  logic [3:0]        wr_strb;
  logic              insn, as_nop, irq_any, watch_wake;

  lpmc_axil_slave u_bus (
    .clk_in      (SYS_CLK_IN),
    .rst_in      (RST_IN),
    .awaddr_in   (S_AXI_AWADDR_IN),
    .awvalid_in  (S_AXI_AWVALID_IN),
    .awready_out (S_AXI_AWREADY_OUT),
    .wdata_in    (S_AXI_WDATA_IN),
    .wstrb_in    (S_AXI_WSTRB_IN),
    .wvalid_in   (S_AXI_WVALID_IN),
    .wready_out  (S_AXI_WREADY_OUT),
    .bresp_out   (S_AXI_BRESP_OUT),
    .bvalid_out  (S_AXI_BVALID_OUT),
    .bready_in   (S_AXI_BREADY_IN),
    .arvalid_in  (S_AXI_ARVALID_IN),
    .arready_out (S_AXI_ARREADY_OUT),
    .rdata_out   (S_AXI_RDATA_OUT),
    .rresp_out   (S_AXI_RRESP_OUT),
    .rvalid_out  (S_AXI_RVALID_OUT),
    .rready_in   (S_AXI_RREADY_IN),
    .wr_en_out   (wr_en),
    .wr_addr_out (wr_addr),
    .wr_data_out (wr_data),
    .wr_strb_out (wr_strb),
    .wr_ok_in    (wr_ok),
    .rd_data_in  (rd_data),
    .rd_ok_in    (rd_ok)
  );

  lpmc_sync #(.WIDTH(1)) u_sck_sync (
    .clk_in   (SYS_CLK_IN),
    .rst_in   (RST_IN),
    .async_in (SERIAL_SCK_PIN_IN),
    .sync_out (sck_sync)
  );

  // Status is read-only; writes to it are refused with an error response.
  assign wr_ok = (wr_addr == CTRL_OFFSET);
  assign rd_ok = (S_AXI_ARADDR_IN == CTRL_OFFSET) || (S_AXI_ARADDR_IN == STATUS_OFFSET);

  always_comb
  begin
    rd_data = '0;
    if (S_AXI_ARADDR_IN == CTRL_OFFSET)
    begin
      rd_data[CTRL_WSEL_POS] = wsel_q;
      rd_data[CTRL_LOW_SPEED_ON_FLAG_POS] = low_speed_on_flag_q;
    end
    else if (S_AXI_ARADDR_IN == STATUS_OFFSET)
    begin
      rd_data[STATUS_MODE_POS +: 5] = mode_q;
      rd_data[STATUS_OPT_POS]       = SUBACTIVE_OPTION;
    end
  end

  // Per-mode clock, retention and pin controls.
  function automatic logic [CTL_W-1:0] ctl_of(input lpmc_mode_type m);
    logic [CTL_W-1:0] c;
    c = '0;
    case (m)
      MODE_ACTIVE:    c = CTL_ACTIVE_RST;
      MODE_STANDBY:
      begin
        c = CTL_ACTIVE_RST;
        c[CTL_CPU_CLK]  = 1'b0;
        c[CTL_RAM_KEEP] = 1'b1;
        c[CTL_REG_KEEP] = 1'b1;
        c[CTL_IO_KEEP]  = 1'b1;
      end
      MODE_STOP:
      begin
        c[CTL_SUB_OSC]   = 1'b1;
        c[CTL_RAM_KEEP]  = 1'b1;
        c[CTL_REG_RST]   = 1'b1;
        c[CTL_PORT_MODE_REG_B_KEEP] = 1'b1;
        c[CTL_IO_RST]    = 1'b1;
      end
      MODE_WATCH:
      begin
        c[CTL_CLK_FUNC] = 1'b1;
        c[CTL_SUB_OSC]  = 1'b1;
        c[CTL_TIMER_A]  = 1'b1;
        c[CTL_RAM_KEEP] = 1'b1;
        c[CTL_REG_KEEP] = 1'b1;
        c[CTL_IO_KEEP]  = 1'b1;
        c[CTL_PIN_DRV]  = 1'b1;
      end
      MODE_SUBACTIVE:
      begin
        c = CTL_ACTIVE_RST;
        c[CTL_SYS_OSC] = 1'b0;
        c[CTL_ADC]     = 1'b0;
      end
      default:        c = CTL_ACTIVE_RST;
    endcase
    return c;
  endfunction : ctl_of

  assign insn       = STOP_INSTRUCTION_IN || STANDBY_INSTRUCTION_IN;
  assign irq_any    = |IRQ_REQUEST_IN;
  assign as_nop     = insn && !GLOBAL_IRQ_ENABLE_IN && irq_any;
  assign watch_wake = IRQ_REQUEST_IN[IRQ_EXTERNAL_IRQ_ZERO_IDX] || IRQ_REQUEST_IN[IRQ_TIMER_A_IDX];

  always_comb
  begin
    mode_d   = mode_q;
    resume_d = 1'b0;
    nop_d    = 1'b0;
    case (mode_q)
      MODE_ACTIVE:
      begin
        if (as_nop && (mode_q == MODE_ACTIVE))
          nop_d = 1'b1;
        else if (STOP_INSTRUCTION_IN)
          mode_d = wsel_q ? MODE_WATCH : MODE_STOP;
        else if (STANDBY_INSTRUCTION_IN)
          mode_d = MODE_STANDBY;
      end
      MODE_STANDBY:
      begin
        if (irq_any)
        begin
          mode_d   = MODE_ACTIVE;
          resume_d = 1'b1;
        end
      end
      MODE_STOP:      mode_d = MODE_STOP;
      MODE_WATCH:
      begin
        if (watch_wake)
          mode_d = (low_speed_on_flag_q && SUBACTIVE_OPTION) ? MODE_SUBACTIVE : MODE_ACTIVE;
      end
      MODE_SUBACTIVE:
      begin
        if (as_nop)
          nop_d = 1'b1;
        else if (insn)
          mode_d = MODE_WATCH;
      end
      default:        mode_d = MODE_ACTIVE;
    endcase
    ctl_d   = ctl_of(mode_d);
    svc_d   = GLOBAL_IRQ_ENABLE_IN && ((mode_d == MODE_ACTIVE) || (mode_d == MODE_SUBACTIVE));
    // Only the external shift clock moves data in watch; stop has no serial.
    shift_d = sck_sync && !sck_prev_q && SERIAL_EXT_CLK_MODE_IN && (mode_q != MODE_STOP);
    wsel_d  = wsel_q;
    low_speed_on_flag_d  = low_speed_on_flag_q;
    if (wr_en && wr_ok && wr_strb[0])
    begin
      wsel_d = wr_data[CTRL_WSEL_POS];
      low_speed_on_flag_d = wr_data[CTRL_LOW_SPEED_ON_FLAG_POS];
    end
  end

  always_ff @(posedge SYS_CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      mode_q     <= MODE_ACTIVE;
      ctl_q      <= CTL_ACTIVE_RST;
      wsel_q     <= CTRL_WSEL_RST;
      low_speed_on_flag_q     <= CTRL_LOW_SPEED_ON_FLAG_RST;
      nop_q      <= 1'b0;
      resume_q   <= 1'b0;
      svc_q      <= 1'b0;
      shift_q    <= 1'b0;
      sck_prev_q <= 1'b0;
    end
    else
    begin
      mode_q     <= mode_d;
      ctl_q      <= ctl_d;
      wsel_q     <= wsel_d;
      low_speed_on_flag_q     <= low_speed_on_flag_d;
      nop_q      <= nop_d;
      resume_q   <= resume_d;
      svc_q      <= svc_d;
      shift_q    <= shift_d;
      sck_prev_q <= sck_sync;
    end
  end

  assign MODE_OUT                 = mode_q;
  assign CPU_CLK_EN_OUT           = ctl_q[CTL_CPU_CLK];
  assign PERIPHERAL_CLOCK_EN_OUT  = ctl_q[CTL_PER_CLK];
  assign CLK_FUNC_EN_OUT          = ctl_q[CTL_CLK_FUNC];
  assign SYS_OSC_EN_OUT           = ctl_q[CTL_SYS_OSC];
  assign SUB_OSC_EN_OUT           = ctl_q[CTL_SUB_OSC];
  assign RAM_RETAIN_OUT           = ctl_q[CTL_RAM_KEEP];
  assign REG_RETAIN_OUT           = ctl_q[CTL_REG_KEEP];
  assign REG_RESET_OUT            = ctl_q[CTL_REG_RST];
  assign PORT_MODE_REG_B_KEEP_OUT = ctl_q[CTL_PORT_MODE_REG_B_KEEP];
  assign IO_RETAIN_OUT            = ctl_q[CTL_IO_KEEP];
  assign IO_RESET_OUT             = ctl_q[CTL_IO_RST];
  assign PIN_DRIVE_EN_OUT         = ctl_q[CTL_PIN_DRV];
  assign ADC_EN_OUT               = ctl_q[CTL_ADC];
  assign TIMER_BC_EN_OUT          = ctl_q[CTL_TIMER_BC];
  assign TIMER_A_EN_OUT           = ctl_q[CTL_TIMER_A];
  assign SERIAL_IRQ_EN_OUT        = ctl_q[CTL_SER_IRQ];
  assign SERIAL_SHIFT_OUT         = shift_q;
  assign IRQ_SERVICE_EN_OUT       = svc_q;
  assign INSN_AS_NOP_OUT          = nop_q;
  assign RESUME_NEXT_OUT          = resume_q;

  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (RST_IN);

  sequence s_active_insn;
    mode_q == MODE_ACTIVE && !as_nop;
  endsequence

  a_stop_holds_forever: assert property (
    mode_q == MODE_STOP |=> (mode_q == MODE_STOP) [*8])
    else $error("Stop mode left without reset.");

  a_standby_entry_clocks: assert property (
    s_active_insn and STANDBY_INSTRUCTION_IN && !STOP_INSTRUCTION_IN
    |=> mode_q == MODE_STANDBY && !CPU_CLK_EN_OUT && PERIPHERAL_CLOCK_EN_OUT && IO_RETAIN_OUT)
    else $error("Standby entry or its clocks wrong.");

  a_stop_entry_select: assert property (
    s_active_insn and STOP_INSTRUCTION_IN && !wsel_q |=> mode_q == MODE_STOP && !SYS_OSC_EN_OUT)
    else $error("Stop entry wrong.");

  a_watch_entry_paths: assert property (
    (s_active_insn and STOP_INSTRUCTION_IN && wsel_q)
    or (mode_q == MODE_SUBACTIVE && insn && !as_nop) |=> mode_q == MODE_WATCH)
    else $error("Watch entry wrong.");

  a_nop_cancel_insn: assert property (
    mode_q == MODE_ACTIVE && as_nop |=> mode_q == MODE_ACTIVE && INSN_AS_NOP_OUT
    ##1 (!INSN_AS_NOP_OUT || $past(as_nop)))
    else $error("Cancelled instruction changed mode.");

  a_standby_wake_resume: assert property (
    mode_q == MODE_STANDBY && irq_any |=> RESUME_NEXT_OUT && CPU_CLK_EN_OUT
    && IRQ_SERVICE_EN_OUT == $past(GLOBAL_IRQ_ENABLE_IN))
    else $error("Standby wake wrong.");

  a_watch_wake_target: assert property (
    mode_q == MODE_WATCH && watch_wake |=>
    mode_q == (($past(low_speed_on_flag_q) && SUBACTIVE_OPTION) ? MODE_SUBACTIVE : MODE_ACTIVE))
    else $error("Watch wake target wrong.");

  a_stop_pins_float: assert property (
    mode_q == MODE_STOP |-> !PIN_DRIVE_EN_OUT && IO_RESET_OUT && REG_RESET_OUT && PORT_MODE_REG_B_KEEP_OUT)
    else $error("Stop pin or register control wrong.");

  a_subactive_option: assert property (
    mode_q == MODE_SUBACTIVE |-> SUBACTIVE_OPTION && ($past(mode_q) inside {MODE_WATCH, MODE_SUBACTIVE}))
    else $error("Subactive reached without option.");

  a_subactive_adc_off: assert property (
    mode_q == MODE_SUBACTIVE |-> !ADC_EN_OUT && PERIPHERAL_CLOCK_EN_OUT && CPU_CLK_EN_OUT)
    else $error("Subactive clock control wrong.");

  a_watch_serial_quiet: assert property (
    mode_q == MODE_WATCH |-> !SERIAL_IRQ_EN_OUT && !PERIPHERAL_CLOCK_EN_OUT)
    else $error("Watch serial interrupt enabled.");
endmodule : lpmc_mode_ctrl
`default_nettype wire

// file: test/lpmc_cpu_model.sv
/*
  CPU core partner: registers bench requests as instruction strobes one cycle later
  and keeps the global interrupt enable flag.
  Assumes the same clock and reset as the mode controller.
*/
`timescale 1ns/1ps
`default_nettype none
module lpmc_cpu_model
(
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic       stop_req_in,
  input  wire logic       stby_req_in,
  input  wire logic       return_from_interrupt_in,
  input  wire logic       svc_in,
  input  wire logic [6:0] irq_in,
  output var  logic       stop_out,
  output var  logic       stby_out,
  output var  logic       ie_out
);
  // Strobes are registered, so no instruction can reach the block during reset.
  always_ff @(posedge clk_in or posedge rst_in)
    if (rst_in)
    begin
      stop_out <= 1'b0;
      stby_out <= 1'b0;
      ie_out   <= 1'b0;
    end
    else
    begin
      stop_out <= stop_req_in;
      stby_out <= stby_req_in;
      if (svc_in && |irq_in)
        ie_out <= 1'b0;
      else if (return_from_interrupt_in)
        ie_out <= 1'b1;
    end
endmodule : lpmc_cpu_model
`default_nettype wire

// file: test/low_power_mode_controller_test.sv
/*
  Self-checking bench for the mode controller with a CPU partner model.
  Assumes a 100 MHz clock and the register map of the package.
*/
`timescale 1ns/1ps
`default_nettype none
module low_power_mode_controller_test;
  import lpmc_pkg::*;
  logic clk = 1'b0, rst = 1'b1, awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
  logic sreq = 1'b0, breq = 1'b0, return_from_interrupt = 1'b0, ext = 1'b0, sck = 1'b0;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, rdat, seed = 32'h25;
  logic [6:0] irq = 7'h00;
  logic stop_i, stby_i, ie, awr, wrdy, bv, arr, rv, svc, nop, res, shf;
  logic s_nop = 1'b0, s_res = 1'b0, s_shf = 1'b0;
  logic [1:0] bresp, rresp;
  logic [4:0] mode;
  wire [15:0] ctl;
  int n_mismatch = 0, comparisons = 0;
  always #5 clk = ~clk;
  always @(negedge clk)
  begin
    s_nop |= nop;
    s_res |= res;
    s_shf |= shf;
  end
  function logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  function logic [15:0] ctl_exp(input logic [4:0] m);
    case (m)
      MODE_STANDBY: return 16'hFA7E;
      MODE_STOP: return 16'h05B0;
      MODE_WATCH: return 16'h4A74;
      MODE_SUBACTIVE: return 16'hE817;
      default: return CTL_ACTIVE_RST;
    endcase
  endfunction : ctl_exp
  task chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task chm(input logic [4:0] m);
    chk({27'h0, mode}, {27'h0, m});
    chk({16'h0, ctl}, {16'h0, ctl_exp(m)});
  endtask : chm
  task op(input logic s, input logic b);
    @(posedge clk);
    sreq <= s;
    breq <= b;
    @(posedge clk);
    sreq <= 1'b0;
    breq <= 1'b0;
    @(posedge clk);
    #1;
  endtask : op
  task wake(input logic [6:0] v);
    @(posedge clk);
    irq <= v;
    repeat (2) @(posedge clk);
    #1;
  endtask : wake
  task do_reset();
    @(posedge clk);
    rst <= 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    #1;
  endtask : do_reset
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    int i;
    @(posedge clk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    for (i = 0; i < 40; i++)
    begin
      @(posedge clk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wrdy) wv <= 1'b0;
      if (bv) break;
    end
    br <= 1'b0;
    if (i == 40) n_mismatch++;
    chk({30'h0, bresp}, {30'h0, e});
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    int i;
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    for (i = 0; i < 40; i++)
    begin
      @(posedge clk);
      if (arv && arr) arv <= 1'b0;
      if (rv) break;
    end
    rr <= 1'b0;
    if (i == 40) n_mismatch++;
    chk(rdat, d);
    chk({30'h0, rresp}, {30'h0, e});
  endtask : rd
  task complete_run();
    $display("comparisons=%0d n_mismatch=%0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : complete_run
  lpmc_cpu_model cpu (.clk_in(clk), .rst_in(rst), .stop_req_in(sreq), .stby_req_in(breq), .return_from_interrupt_in(return_from_interrupt),
    .svc_in(svc), .irq_in(irq), .stop_out(stop_i), .stby_out(stby_i), .ie_out(ie));
  lpmc_mode_ctrl DUT (.SYS_CLK_IN(clk), .RST_IN(rst), .S_AXI_AWADDR_IN(awa), .S_AXI_AWVALID_IN(awv),
    .S_AXI_AWREADY_OUT(awr), .S_AXI_WDATA_IN(wd), .S_AXI_WSTRB_IN(4'hF), .S_AXI_WVALID_IN(wv),
    .S_AXI_WREADY_OUT(wrdy), .S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bv), .S_AXI_BREADY_IN(br),
    .S_AXI_ARADDR_IN(ara), .S_AXI_ARVALID_IN(arv), .S_AXI_ARREADY_OUT(arr), .S_AXI_RDATA_OUT(rdat),
    .S_AXI_RRESP_OUT(rresp), .S_AXI_RVALID_OUT(rv), .S_AXI_RREADY_IN(rr), .STANDBY_INSTRUCTION_IN(stby_i),
    .STOP_INSTRUCTION_IN(stop_i), .GLOBAL_IRQ_ENABLE_IN(ie), .IRQ_REQUEST_IN(irq),
    .SERIAL_EXT_CLK_MODE_IN(ext), .SERIAL_SCK_PIN_IN(sck), .MODE_OUT(mode),
    .CPU_CLK_EN_OUT(ctl[CTL_CPU_CLK]), .PERIPHERAL_CLOCK_EN_OUT(ctl[CTL_PER_CLK]),
    .CLK_FUNC_EN_OUT(ctl[CTL_CLK_FUNC]), .SYS_OSC_EN_OUT(ctl[CTL_SYS_OSC]), .SUB_OSC_EN_OUT(ctl[CTL_SUB_OSC]),
    .RAM_RETAIN_OUT(ctl[CTL_RAM_KEEP]), .REG_RETAIN_OUT(ctl[CTL_REG_KEEP]), .REG_RESET_OUT(ctl[CTL_REG_RST]),
    .PORT_MODE_REG_B_KEEP_OUT(ctl[CTL_PORT_MODE_REG_B_KEEP]), .IO_RETAIN_OUT(ctl[CTL_IO_KEEP]),
    .IO_RESET_OUT(ctl[CTL_IO_RST]), .PIN_DRIVE_EN_OUT(ctl[CTL_PIN_DRV]), .ADC_EN_OUT(ctl[CTL_ADC]),
    .TIMER_BC_EN_OUT(ctl[CTL_TIMER_BC]), .TIMER_A_EN_OUT(ctl[CTL_TIMER_A]),
    .SERIAL_IRQ_EN_OUT(ctl[CTL_SER_IRQ]), .SERIAL_SHIFT_OUT(shf), .IRQ_SERVICE_EN_OUT(svc),
    .INSN_AS_NOP_OUT(nop), .RESUME_NEXT_OUT(res));
  // The watchdog allows many times the expected run, so it only trips on a hang.
  initial
  begin
    #200000;
    n_mismatch++;
    complete_run();
  end
  initial
  begin
    do_reset();
    chm(MODE_ACTIVE);
    rd(STATUS_OFFSET, 32'h00000101, RESP_OKAY);
    wr(STATUS_OFFSET, 32'h3, RESP_SLVERR);
    rd(8'h08, 32'h0, RESP_SLVERR);
    wr(CTRL_OFFSET, 32'h1, RESP_OKAY);
    rd(CTRL_OFFSET, 32'h1, RESP_OKAY);
    op(1'b1, 1'b0);
    chm(MODE_WATCH);
    @(posedge clk);
    ext <= 1'b1;
    sck <= 1'b1;
    repeat (6) @(posedge clk);
    sck <= 1'b0;
    #1;
    chk(s_shf, 1'b1);
    op(1'b0, 1'b1);
    wake(7'h02);
    chm(MODE_WATCH);
    wake(7'h04);
    chm(MODE_ACTIVE);
    wake(7'h00);
    return_from_interrupt <= 1'b1;
    @(posedge clk);
    return_from_interrupt <= 1'b0;
    op(1'b0, 1'b1);
    chm(MODE_STANDBY);
    wake(7'(1 << (xs() % 7)));
    chm(MODE_ACTIVE);
    chk(s_res, 1'b1);
    chk(svc, 1'b1);
    wake(7'(xs()) | 7'h01);
    op(1'b1, 1'b0);
    @(posedge clk);
    #1;
    chk(s_nop, 1'b1);
    chm(MODE_ACTIVE);
    chk(svc, 1'b0);
    wake(7'h00);
    wr(CTRL_OFFSET, 32'h3, RESP_OKAY);
    op(1'b1, 1'b0);
    wake(7'h01);
    chm(MODE_SUBACTIVE);
    wake(7'h00);
    op(1'b0, 1'b1);
    chm(MODE_WATCH);
    do_reset();
    chm(MODE_ACTIVE);
    op(1'b1, 1'b0);
    chm(MODE_STOP);
    wake(7'h05);
    op(1'b0, 1'b1);
    chm(MODE_STOP);
    do_reset();
    chm(MODE_ACTIVE);
    complete_run();
  end
endmodule : low_power_mode_controller_test
`default_nettype wire
